// file: rtl/sdh_path_defect_monitor.sv
// Sink-side defect supervision for path and section trail terminations.
// Overview of operation
// - Fault causes gated by termination mode.
// - Monitored in service, unmonitored otherwise.
// - Port mode: monitored, auto-arm, unmonitored.
// - Reset to auto-arm if supported.
// - Unequipped and alarm indication declared only after persistence check.
// - Hardware faults join fault cause output.
// - High order unequipped: C2 zero, five frames.
// - Low order unequipped: V5 bits 000.
// - High order alarm indication: C2 all ones.
// - Low order alarm indication: V5 bits 111.
// - No tandem overhead: alarm indication false.
// - Optional transmit trace byte insertion.
// - Trace check not required: mismatch false.
// - Mismatch compares expected and accepted trace.
// - Disable command forces mismatch false.
// - CRC or alignment error gives mismatch.
// - Accepted trace reported to management.
// - Bursty model: excessive error held false.
// - Poisson excessive error from rate detector.
// - Poisson degraded signal from rate detector.
// - Detection probability met by rate detector.
// - Clearing probability met by rate detector.
// - Bursty degraded after count of bad seconds.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sdh_path_defect_monitor
   import sdh_defect_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdData,
   input  wire logic        frameStb,
   input  wire logic [7:0]  pathSignalLabel,
   input  wire logic [7:0]  traceByteRx,
   input  wire logic        traceCrcErr,
   input  wire logic        traceAlignErr,
   input  wire logic        hwFault,
   input  wire logic        signalLossDefect,
   input  wire logic        berExcDetect,
   input  wire logic        berDegDetect,
   input  wire logic        secondStb,
   input  wire logic        badInterval,
   output logic [7:0]       traceByteTx,
   output logic             unequippedDefect,
   output logic             vcAlarmIndicationDefect,
   output logic             traceMismatchDefect,
   output logic             excessiveErrorDefect,
   output logic             degradedSignalDefect,
   output logic             faultCause
);

   // ==========================================================
   // Register state
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [7:0]  txTrace_reg;
   logic [7:0]  txTrace_next;
   logic [7:0]  expTrace_reg;
   logic [7:0]  expTrace_next;
   logic [7:0]  accTrace_reg;
   logic [7:0]  accTrace_next;
   logic [3:0]  badIntervalCount_reg;
   logic [3:0]  badIntervalCount_next;
   logic [31:0] rdData_reg;
   logic [31:0] rdData_next;
   port_mode_t  port_reg;
   port_mode_t  port_next;

   // Pin synchronisers for the physical-layer loss indication.
   logic        losS1_reg;
   logic        losS2_reg;
   logic        losS3_reg;
   logic        losStable_reg;
   logic        losStable_next;

   logic        uneqRaw;
   logic        aisRaw;
   logic        uneqMatch;
   logic        aisMatch;
   logic        timRaw;
   logic        timNext;
   logic        tim_reg;
   logic        exc_reg;
   logic        excNext;
   logic        deg_reg;
   logic        degNext;
   logic [3:0]  badRun_reg;
   logic [3:0]  badRun_next;
   logic        monitored;
   logic        lowOrder;
   logic [31:0] statusWord;

   assign lowOrder = ctrl_reg[CTRL_LOW_ORDER];

   // ==========================================================
   // Signal label matching, per payload order.
   always_comb begin
      if (lowOrder) begin
         uneqMatch = pathSignalLabel[2:0] == V5_UNEQ;
         aisMatch  = pathSignalLabel[2:0] == V5_AIS;
      end else begin
         uneqMatch = pathSignalLabel == TSL_UNEQ;
         aisMatch  = pathSignalLabel == TSL_AIS;
      end
   end

   persist_filter uUneq (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .frameStb (frameStb),
      .match    (uneqMatch),
      .defect   (uneqRaw)
   );

   persist_filter uAis (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .frameStb (frameStb),
      .match    (aisMatch),
      .defect   (aisRaw)
   );

   // ==========================================================
   // Loss indication comes from another clock domain; a change counts once stages agree.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         losS1_reg     <= 1'b1;
         losS2_reg     <= 1'b1;
         losS3_reg     <= 1'b1;
         losStable_reg <= 1'b1;
      end else begin
         losS1_reg     <= signalLossDefect;
         losS2_reg     <= losS1_reg;
         losS3_reg     <= losS2_reg;
         losStable_reg <= losStable_next;
      end
   end

   always_comb begin
      losStable_next = losStable_reg;
      if (losS2_reg == losS3_reg) begin
         losStable_next = losS2_reg;
      end
   end

   // ==========================================================
   // Port mode: software writes take effect, auto-arm promotes itself once loss clears.
   always_comb begin
      port_next = port_reg;
      if (regWr && regAddr == ADDR_CTRL && regWrData[CTRL_PORT_WR]) begin
         unique case (regWrData[CTRL_PORT_LSB +: 2])
            2'h1:    port_next = AUTO_SUPPORTED ? PORT_AUTO : PORT_UNMON;
            2'h2:    port_next = PORT_MON;
            default: port_next = PORT_UNMON;
         endcase
      end else if (port_reg == PORT_AUTO && !losStable_reg) begin
         port_next = PORT_MON;
      end
   end

   // Fault causes only leave the block while both modes say monitored.
   assign monitored = ctrl_reg[CTRL_TP_MON] && port_reg == PORT_MON;

   // ==========================================================
   // Trace and error defects.
   always_comb begin
      accTrace_next = accTrace_reg;
      timRaw        = tim_reg;
      if (frameStb) begin
         accTrace_next = traceByteRx;
         timRaw = traceByteRx != expTrace_reg || traceCrcErr || traceAlignErr;
      end
      if (!ctrl_reg[CTRL_TIM_EN] || ctrl_reg[CTRL_TIM_DIS]) begin
         timNext = 1'b0;
      end else begin
         timNext = timRaw;
      end
   end

   // Bursty model counts consecutive bad seconds; the rate detector serves the Poisson model.
   always_comb begin
      badRun_next = badRun_reg;
      degNext     = deg_reg;
      excNext     = 1'b0;
      if (ctrl_reg[CTRL_BURSTY]) begin
         if (secondStb) begin
            if (badInterval) begin
               if (badRun_reg < badIntervalCount_reg) begin
                  badRun_next = badRun_reg + 4'h1;
               end
               if (badRun_reg + 4'h1 >= badIntervalCount_reg) begin
                  degNext = 1'b1;
               end
            end else begin
               badRun_next = 4'h0;
               degNext     = 1'b0;
            end
         end
      end else begin
         badRun_next = 4'h0;
         excNext     = berExcDetect;
         degNext     = berDegDetect;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tim_reg    <= 1'b0;
         exc_reg    <= 1'b0;
         deg_reg    <= 1'b0;
         badRun_reg <= 4'h0;
      end else begin
         tim_reg    <= timNext;
         exc_reg    <= excNext;
         deg_reg    <= degNext;
         badRun_reg <= badRun_next;
      end
   end

   // ==========================================================
   // Register writes. A bad-interval count outside its range is clamped.
   always_comb begin
      ctrl_next             = ctrl_reg;
      txTrace_next          = txTrace_reg;
      expTrace_next         = expTrace_reg;
      badIntervalCount_next = badIntervalCount_reg;
      if (regWr) begin
         unique case (regAddr)
            ADDR_CTRL:      ctrl_next     = regWrData;
            ADDR_TX_TRACE:  txTrace_next  = regWrData[7:0];
            ADDR_EXP_TRACE: expTrace_next = regWrData[7:0];
            ADDR_DEG_CFG: begin
               if (regWrData[3:0] < BAD_INTERVAL_COUNT_MIN) begin
                  badIntervalCount_next = BAD_INTERVAL_COUNT_MIN;
               end else if (regWrData[3:0] > BAD_INTERVAL_COUNT_MAX) begin
                  badIntervalCount_next = BAD_INTERVAL_COUNT_MAX;
               end else begin
                  badIntervalCount_next = regWrData[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   assign statusWord = {22'h0, port_reg, 1'b0, losStable_reg, faultCause,
                        degradedSignalDefect, excessiveErrorDefect,
                        traceMismatchDefect, vcAlarmIndicationDefect, unequippedDefect};

   // Read data stands in the cycle after the strobe; unmapped addresses read zero.
   always_comb begin
      rdData_next = 32'h0;
      if (regRd) begin
         unique case (regAddr)
            ADDR_CTRL:      rdData_next = ctrl_reg;
            ADDR_STATUS:    rdData_next = statusWord;
            ADDR_TX_TRACE:  rdData_next = {24'h0, txTrace_reg};
            ADDR_EXP_TRACE: rdData_next = {24'h0, expTrace_reg};
            ADDR_ACC_TRACE: rdData_next = {24'h0, accTrace_reg};
            ADDR_BER:       rdData_next = {30'h0, berDegDetect, berExcDetect};
            ADDR_DEG_CFG:   rdData_next = {28'h0, badIntervalCount_reg};
            default:        rdData_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg             <= CTRL_RESET;
         txTrace_reg          <= TX_TRACE_RESET;
         expTrace_reg         <= 8'h00;
         accTrace_reg         <= 8'h00;
         badIntervalCount_reg <= BAD_INTERVAL_COUNT_RESET;
         rdData_reg           <= 32'h0;
         port_reg             <= AUTO_SUPPORTED ? PORT_AUTO : PORT_UNMON;
      end else begin
         ctrl_reg             <= ctrl_next;
         txTrace_reg          <= txTrace_next;
         expTrace_reg         <= expTrace_next;
         accTrace_reg         <= accTrace_next;
         badIntervalCount_reg <= badIntervalCount_next;
         rdData_reg           <= rdData_next;
         port_reg             <= port_next;
      end
   end

   // ==========================================================
   // Outputs. Defects report raw except alarm indication, masked without tandem overhead; only the fault cause is gated by mode.
   assign regRdData               = rdData_reg;
   assign traceByteTx             = ctrl_reg[CTRL_TRACE_GEN] ? txTrace_reg : TX_TRACE_RESET;
   assign unequippedDefect        = uneqRaw;
   assign vcAlarmIndicationDefect = ctrl_reg[CTRL_TCM_NET] && aisRaw;
   assign traceMismatchDefect     = tim_reg;
   assign excessiveErrorDefect    = exc_reg;
   assign degradedSignalDefect    = deg_reg;
   // Hardware faults enter the same path as transmission causes.
   assign faultCause = monitored && (uneqRaw || vcAlarmIndicationDefect || tim_reg
                       || exc_reg || deg_reg || hwFault);

   // ==========================================================
   // Checks.
   // A frame carrying the alarm pattern was taken one clock back.
   sequence s_aisFrameSeen;
      $past(frameStb) && $past(aisMatch);
   endsequence

   AST_AIS_OFF_NO_TCM: assert property (@(posedge mclk) disable iff (!arst_n)
      !ctrl_reg[CTRL_TCM_NET] |-> !vcAlarmIndicationDefect)
      else $error("alarm indication set without tandem overhead");
   AST_TIM_DIS: assert property (@(posedge mclk) disable iff (!arst_n)
      ctrl_reg[CTRL_TIM_DIS] |=> !traceMismatchDefect)
      else $error("trace mismatch set while disabled");
   AST_TIM_NOT_EN: assert property (@(posedge mclk) disable iff (!arst_n)
      !ctrl_reg[CTRL_TIM_EN] |=> !traceMismatchDefect)
      else $error("trace mismatch set while not enabled");
   AST_EXC_BURSTY: assert property (@(posedge mclk) disable iff (!arst_n)
      ctrl_reg[CTRL_BURSTY] |=> !excessiveErrorDefect)
      else $error("excessive error set under bursty model");
   AST_UNEQ_RISE: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(unequippedDefect) |-> $past(frameStb) && $past(uneqMatch))
      else $error("unequipped rose without matching frame");
   AST_AIS_RISE: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(aisRaw) |-> s_aisFrameSeen)
      else $error("alarm indication rose without matching frame");
   AST_AUTO_ARM: assert property (@(posedge mclk) disable iff (!arst_n)
      port_reg == PORT_AUTO && !losStable_reg && !regWr |=> port_reg == PORT_MON)
      else $error("auto-arm did not promote");
   AST_CAUSE_GATE: assert property (@(posedge mclk) disable iff (!arst_n)
      port_reg != PORT_MON |-> !faultCause)
      else $error("fault cause outside monitored mode");
   AST_ACC_TRACE: assert property (@(posedge mclk) disable iff (!arst_n)
      frameStb |=> accTrace_reg == $past(traceByteRx))
      else $error("accepted trace not captured");

endmodule // sdh_path_defect_monitor

// file: rtl/sdh_defect_pkg.sv
// Package of constants and types for the path defect monitor.
package sdh_defect_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_TX_TRACE  = 8'h08;
   localparam logic [7:0] ADDR_EXP_TRACE = 8'h0c;
   localparam logic [7:0] ADDR_ACC_TRACE = 8'h10;
   localparam logic [7:0] ADDR_BER       = 8'h14;
   localparam logic [7:0] ADDR_DEG_CFG   = 8'h18;

   // ==========================================================
   // Control register fields
   localparam int CTRL_TP_MON      = 0;
   localparam int CTRL_LOW_ORDER   = 1;
   localparam int CTRL_TCM_NET     = 2;
   localparam int CTRL_TIM_EN      = 3;
   localparam int CTRL_TIM_DIS     = 4;
   localparam int CTRL_BURSTY      = 5;
   localparam int CTRL_TRACE_GEN   = 6;
   localparam int CTRL_PORT_LSB    = 8;
   localparam int CTRL_PORT_WR     = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ==========================================================
   // Status register fields
   localparam int ST_UNEQ  = 0;
   localparam int ST_AIS   = 1;
   localparam int ST_TIM   = 2;
   localparam int ST_EXC   = 3;
   localparam int ST_DEG   = 4;
   localparam int ST_CAUSE = 5;
   localparam int ST_PORT  = 8;

   // ==========================================================
   // Persistence and degraded-signal limits
   localparam logic [2:0] PERSIST_FRAMES = 3'h5;
   localparam logic [3:0] BAD_INTERVAL_COUNT_MIN       = 4'h2;
   localparam logic [3:0] BAD_INTERVAL_COUNT_MAX       = 4'ha;
   localparam logic [3:0] BAD_INTERVAL_COUNT_RESET     = 4'h2;
   localparam logic [7:0] TSL_UNEQ       = 8'h00;
   localparam logic [7:0] TSL_AIS        = 8'hff;
   localparam logic [2:0] V5_UNEQ        = 3'h0;
   localparam logic [2:0] V5_AIS         = 3'h7;
   localparam logic [7:0] TX_TRACE_RESET = 8'h00;
   localparam bit         AUTO_SUPPORTED = 1'b1;

   // Port mode states.
   typedef enum logic [1:0] {
      PORT_UNMON,
      PORT_AUTO,
      PORT_MON
   } port_mode_t;

endpackage

// file: rtl/persist_filter.sv
// Five-frame persistence filter for a single defect.
`timescale 1ns/1ps
module persist_filter
   import sdh_defect_pkg::*;
(
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic frameStb,
   input  wire logic match,
   output logic      defect
);

   logic [2:0] runCnt_reg;
   logic [2:0] runCnt_next;
   logic       defect_reg;
   logic       defect_next;

   // A frame that disagrees with the current defect state lengthens the run; one that agrees
   // restarts it, so only unbroken runs of five flip the state.
   always_comb begin
      runCnt_next = runCnt_reg;
      defect_next = defect_reg;
      if (frameStb) begin
         if (match == defect_reg) begin
            runCnt_next = 3'h0;
         end else if (runCnt_reg == PERSIST_FRAMES - 3'h1) begin
            runCnt_next = 3'h0;
            defect_next = match;
         end else begin
            runCnt_next = runCnt_reg + 3'h1;
         end
      end
   end

   // State registers.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         runCnt_reg <= 3'h0;
         defect_reg <= 1'b0;
      end else begin
         runCnt_reg <= runCnt_next;
         defect_reg <= defect_next;
      end
   end

   assign defect = defect_reg;

endmodule // persist_filter

// file: verif/sdh_far_end_model.sv
// Far-end network element model that sends path overhead, one frame every four clocks.
`timescale 1ns/1ps
module sdh_far_end_model (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       sendEn,
   input  wire logic [7:0] txLabel,
   input  wire logic [7:0] txTrace,
   input  wire logic       txCrcBad,
   input  wire logic       txAlignBad,
   output logic            frameStb,
   output logic [7:0]      pathSignalLabel,
   output logic [7:0]      traceByteRx,
   output logic            traceCrcErr,
   output logic            traceAlignErr
);
   logic [1:0] gapCnt_reg;

   // ==========================================================
   // Frame generation
   // Between strobes the overhead lines are inverted every clock, so a receiver that samples
   // outside the strobe sees garbage rather than a conveniently held value.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gapCnt_reg <= 2'h0;
         frameStb <= 1'b0;
         pathSignalLabel <= 8'h00;
         traceByteRx <= 8'h00;
         traceCrcErr <= 1'b0;
         traceAlignErr <= 1'b0;
      end else if (sendEn && gapCnt_reg == 2'h3) begin
         gapCnt_reg <= 2'h0;
         frameStb <= 1'b1;
         pathSignalLabel <= txLabel;
         traceByteRx <= txTrace;
         traceCrcErr <= txCrcBad;
         traceAlignErr <= txAlignBad;
      end else begin
         gapCnt_reg <= sendEn ? gapCnt_reg + 2'h1 : 2'h0;
         frameStb <= 1'b0;
         pathSignalLabel <= ~pathSignalLabel;
         traceByteRx <= ~traceByteRx;
         traceCrcErr <= ~traceCrcErr;
         traceAlignErr <= ~traceAlignErr;
      end
   end
endmodule // sdh_far_end_model

// file: verif/sdh_path_defect_monitor_tb.sv
// Self-checking testbench for the path defect monitor.
`timescale 1ns/1ps
module sdh_path_defect_monitor_tb;
   import sdh_defect_pkg::*;
   logic mclk, arst_n, regWr, regRd, frameStb, traceCrcErr, traceAlignErr, hwFault;
   logic signalLossDefect, berExcDetect, berDegDetect, secondStb, badInterval, sendEn;
   logic txCrcBad, txAlignBad, uneq, ais, tim, exc, deg, faultCause;
   logic [7:0] regAddr, pathSignalLabel, traceByteRx, traceByteTx, txLabel, txTrace;
   logic [31:0] regWrData, regRdData, rdv;
   int error_cnt, comparisons;
   typedef struct {logic [31:0] c; logic [7:0] l; int n; logic u; logic a;} row_t;
   // Rows run in order and carry filter state from one to the next.
   row_t rows[8] = '{'{32'h5, 8'h00, 5, 1, 0}, '{32'h5, 8'hff, 4, 1, 0},
      '{32'h5, 8'hff, 1, 0, 1}, '{32'h5, 8'h5a, 5, 0, 0}, '{32'h7, 8'hf8, 5, 1, 0},
      '{32'h7, 8'h07, 5, 0, 1}, '{32'h3, 8'h07, 5, 0, 0}, '{32'h7, 8'h05, 5, 0, 0}};

   sdh_path_defect_monitor sdh_path_defect_monitor_i (.mclk(mclk), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .frameStb(frameStb), .pathSignalLabel(pathSignalLabel),
      .traceByteRx(traceByteRx), .traceCrcErr(traceCrcErr), .traceAlignErr(traceAlignErr),
      .hwFault(hwFault), .signalLossDefect(signalLossDefect), .berExcDetect(berExcDetect),
      .berDegDetect(berDegDetect), .secondStb(secondStb), .badInterval(badInterval),
      .traceByteTx(traceByteTx), .unequippedDefect(uneq), .vcAlarmIndicationDefect(ais),
      .traceMismatchDefect(tim), .excessiveErrorDefect(exc), .degradedSignalDefect(deg),
      .faultCause(faultCause));
   sdh_far_end_model sdh_far_end_model_i (.mclk(mclk), .arst_n(arst_n), .sendEn(sendEn),
      .txLabel(txLabel), .txTrace(txTrace), .txCrcBad(txCrcBad), .txAlignBad(txAlignBad),
      .frameStb(frameStb), .pathSignalLabel(pathSignalLabel), .traceByteRx(traceByteRx),
      .traceCrcErr(traceCrcErr), .traceAlignErr(traceAlignErr));

   // ==========================================================
   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (50000) @(posedge mclk);
      error_cnt++;
      test_done();
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // Sends n frames with a bounded wait, then lets the defect outputs settle.
   task automatic frames(input int n);
      int k;
      int t;
      k = 0;
      t = 0;
      sendEn <= 1'b1;
      while (k < n && t < n * 8 + 8) begin
         @(posedge mclk);
         t++;
         if (frameStb === 1'b1) k++;
      end
      sendEn <= 1'b0;
      if (k < n) begin
         error_cnt++;
         test_done();
      end
      repeat (2) @(posedge mclk);
   endtask
   task automatic timCase(input logic [31:0] c, input logic [7:0] tr, input logic cb,
                          input logic ab, input logic e);
      wr(ADDR_CTRL, c);
      txTrace <= tr;
      txCrcBad <= cb;
      txAlignBad <= ab;
      frames(1);
      chk("trace mismatch", {31'h0, e}, {31'h0, tim});
   endtask
   task automatic sec(input logic bad);
      @(posedge mclk);
      secondStb <= 1'b1;
      badInterval <= bad;
      @(posedge mclk);
      secondStb <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {regWr, regRd, hwFault, berExcDetect, berDegDetect, secondStb, badInterval} = '0;
      {sendEn, txCrcBad, txAlignBad, regAddr, regWrData, txLabel, txTrace} = '0;
      signalLossDefect = 1'b1;
      arst_n = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk);
      chk("defects in reset", 32'h0, {uneq, ais, tim, exc, deg, faultCause});
      arst_n <= 1'b1;
      rd(ADDR_STATUS, rdv);
      chk("port mode after reset", {30'h0, PORT_AUTO}, {30'h0, rdv[9:8]});
      rd(ADDR_CTRL, rdv);
      chk("ctrl reset", CTRL_RESET, rdv);
      rd(ADDR_DEG_CFG, rdv);
      chk("count reset", {28'h0, BAD_INTERVAL_COUNT_RESET}, rdv);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, rdv);
      chk("unmapped read", 32'h0, rdv);
      signalLossDefect <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(ADDR_STATUS, rdv);
      chk("auto arm to monitored", {30'h0, PORT_MON}, {30'h0, rdv[9:8]});
      // Ordinary label cases.
      foreach (rows[i]) begin
         wr(ADDR_CTRL, rows[i].c);
         txLabel <= rows[i].l;
         frames(rows[i].n);
         chk("unequipped", {31'h0, rows[i].u}, {31'h0, uneq});
         chk("alarm indication", {31'h0, rows[i].a}, {31'h0, ais});
         chk("fault cause", {31'h0, rows[i].u | rows[i].a}, {31'h0, faultCause});
      end
      // A broken run of unequipped frames starts the count again.
      wr(ADDR_CTRL, 32'h5);
      txLabel <= 8'h00;
      frames(4);
      txLabel <= 8'h5a;
      frames(1);
      txLabel <= 8'h00;
      frames(4);
      chk("broken run", 32'h0, {31'h0, uneq});
      frames(1);
      chk("restarted run", 32'h1, {31'h0, uneq});
      wr(ADDR_CTRL, 32'h4);
      // A write lands on the edge that ends the task, so its effect is looked at one edge on.
      @(posedge mclk);
      chk("fault cause unmonitored", 32'h0, {31'h0, faultCause});
      wr(ADDR_CTRL, 32'h5);
      txLabel <= 8'h5a;
      frames(5);
      hwFault <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("hardware fault cause", 32'h1, {31'h0, faultCause});
      wr(ADDR_CTRL, 32'h401);
      rd(ADDR_STATUS, rdv);
      chk("port unmonitored", {30'h0, PORT_UNMON}, {30'h0, rdv[9:8]});
      chk("fault cause port off", 32'h0, {31'h0, faultCause});
      hwFault <= 1'b0;
      wr(ADDR_CTRL, 32'h601);
      // The expected trace is 5a, and control 9 leaves the disable command false.
      wr(ADDR_EXP_TRACE, 32'h5a);
      timCase(32'h9, 8'h5a, 1'b0, 1'b0, 1'b0);
      rd(ADDR_ACC_TRACE, rdv);
      chk("accepted trace", 32'h5a, rdv);
      timCase(32'h9, 8'h33, 1'b0, 1'b0, 1'b1);
      timCase(32'h19, 8'h33, 1'b0, 1'b0, 1'b0);
      timCase(32'h9, 8'h5a, 1'b1, 1'b0, 1'b1);
      // Detection off clears the mismatch, so the alignment case starts from false.
      timCase(32'h1, 8'h33, 1'b0, 1'b0, 1'b0);
      timCase(32'h9, 8'h5a, 1'b0, 1'b1, 1'b1);
      wr(ADDR_TX_TRACE, 32'ha5);
      wr(ADDR_CTRL, 32'h41);
      @(posedge mclk);
      chk("trace inserted", 32'ha5, {24'h0, traceByteTx});
      wr(ADDR_CTRL, 32'h1);
      @(posedge mclk);
      chk("trace fixed", {24'h0, TX_TRACE_RESET}, {24'h0, traceByteTx});
      berExcDetect <= 1'b1;
      berDegDetect <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("excessive poisson", 32'h1, {31'h0, exc});
      chk("degraded poisson", 32'h1, {31'h0, deg});
      rd(ADDR_BER, rdv);
      chk("rate detector status", 32'h3, rdv);
      wr(ADDR_DEG_CFG, 32'h1);
      rd(ADDR_DEG_CFG, rdv);
      chk("count clamp", {28'h0, BAD_INTERVAL_COUNT_MIN}, rdv);
      wr(ADDR_CTRL, 32'h21);
      repeat (2) @(posedge mclk);
      chk("excessive bursty", 32'h0, {31'h0, exc});
      // The degraded state left by the rate detector holds until a good second clears it.
      sec(1'b0);
      chk("first good second", 32'h0, {31'h0, deg});
      sec(1'b1);
      chk("one bad second", 32'h0, {31'h0, deg});
      sec(1'b1);
      chk("two bad seconds", 32'h1, {31'h0, deg});
      sec(1'b0);
      chk("good second", 32'h0, {31'h0, deg});
      test_done();
   end
endmodule // sdh_path_defect_monitor_tb
